// [acr_pkg.sv]
// shared constants of the calibration register set and correction path
package acr_pkg;
	// ************************************************************
	// register byte offsets on the avalon slave
	// ************************************************************
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_IN_OFS = 8'h04;
	localparam logic [7:0] ADDR_REF_OFS = 8'h08;
	localparam logic [7:0] ADDR_TRIM = 8'h0C;
	localparam logic [7:0] ADDR_PROP_OFS = 8'h10;
	localparam logic [7:0] ADDR_GAIN = 8'h14;
	localparam logic [7:0] ADDR_STATUS = 8'h18;
	localparam logic [7:0] ADDR_RESULT = 8'h1C;
	// ************************************************************
	// field positions
	// ************************************************************
	localparam int CTRL_EN_BIT = 0; // correction enable
	localparam int ST_CAL_RANGE_BIT = 0; // gain within 0.8 .. 1.2
	localparam int ST_LOW_RES_BIT = 1; // gain above 1.2
	localparam int ST_UNSUP_BIT = 2; // gain below 0.5
	localparam int GAIN_FRAC = 23; // fraction bits of the gain word
	// ************************************************************
	// reset values and limits
	// ************************************************************
	localparam logic RST_CTRL_EN = 1'b1;
	localparam logic [23:0] RST_OFS = 24'h000000;
	localparam logic [3:0] RST_TRIM = 4'h0;
	localparam logic [23:0] RST_GAIN = 24'h800000; // exactly 1.0
	localparam logic [23:0] GAIN_CAL_MIN = 24'h666666; // 0.8
	localparam logic [23:0] GAIN_CAL_MAX = 24'h999999; // 1.2
	localparam logic [23:0] GAIN_OP_MIN = 24'h400000; // 0.5
	localparam logic [23:0] SAT_POS = 24'h7FFFFF;
	localparam logic [23:0] SAT_NEG = 24'h800000;
	// ************************************************************
	// targets of the on-chip calibration engine
	// ************************************************************
	typedef enum logic [2:0] {
		ACR_T_IN = 3'b000,
		ACR_T_REF = 3'b001,
		ACR_T_TRIM = 3'b010,
		ACR_T_PROP = 3'b011,
		ACR_T_GAIN = 3'b100
	} acr_tgt_e;
endpackage : acr_pkg

// [acr_calib_regs.sv]
// calibration registers, avalon slave and digital correction path
//
// The implementer's own choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ns
// ************************************************************
// Overview of operation
// - holders: two fixed offsets, trim, proportional, gain
// - fixed offsets are 24-bit two's complement words
// - proportional offset is 24-bit two's complement
// - trim code coarse, proportional word removed digitally
// - host reads/writes all; writes replace calibration
// - gain is unsigned, lsb 2^-23, up to 2
// - gain calibration result kept within 0.8..1.2
// - reset loads unity gain and defaults
// - host gains 0.5 to 2.0 still convert
// ************************************************************
module acr_calib_regs (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic raw_valid,
	input wire logic raw_chan,
	input wire logic [23:0] raw_data,
	input wire logic cal_load,
	input wire logic [2:0] cal_target,
	input wire logic [23:0] cal_value,
	output logic [3:0] trim_dac_code,
	output logic out_valid,
	output logic out_chan,
	output logic [23:0] out_data
);
	// ************************************************************
	// storage
	// ************************************************************
	logic wait_ff; // drives waitrequest, high when idle
	logic [31:0] rdata_ff; // read data register
	logic en_ff; // correction enable
	logic [23:0] in_ofs_ff; // fixed offset, input channel
	logic [23:0] ref_ofs_ff; // fixed offset, reference channel
	logic [3:0] trim_ff; // coarse trim dac code
	logic [23:0] prop_ofs_ff; // proportional offset
	logic [23:0] gain_ff; // gain factor, 1.0 = 800000
	logic [23:0] last_ff; // last corrected word
	logic v1_ff; // stage one valid
	logic ch1_ff; // stage one channel
	logic byp1_ff; // stage one bypass
	logic signed [25:0] diff_ff; // raw minus offsets
	logic v2_ff;
	logic ch2_ff;
	logic [23:0] res_ff;
	// ************************************************************
	// byte lane merge for the 24-bit words
	// ************************************************************
	function automatic logic [23:0] merge(input logic [23:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		logic [23:0] m;
		m = old;
		for (int i = 0; i < 3; i++) begin
			if (be[i]) begin
				m[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return m;
	endfunction : merge
	// ************************************************************
	// bus decode
	// ************************************************************
	// a request is taken on the edge where waitrequest is still high;
	// the next cycle shows waitrequest low for exactly one cycle
	wire acc = (avs_read | avs_write) & wait_ff;
	// a write lands only at the answer edge, where the master sees the
	// transfer complete; landing earlier would run ahead of the handshake
	wire wr_acc = avs_write & ~wait_ff;
	wire wr_ctrl = wr_acc & (avs_address == acr_pkg::ADDR_CTRL);
	wire wr_in = wr_acc & (avs_address == acr_pkg::ADDR_IN_OFS);
	wire wr_ref = wr_acc & (avs_address == acr_pkg::ADDR_REF_OFS);
	wire wr_trim = wr_acc & (avs_address == acr_pkg::ADDR_TRIM);
	wire wr_prop = wr_acc & (avs_address == acr_pkg::ADDR_PROP_OFS);
	wire wr_gain = wr_acc & (avs_address == acr_pkg::ADDR_GAIN);
	// calibration engine hits
	wire cl_in = cal_load & (cal_target == acr_pkg::ACR_T_IN);
	wire cl_ref = cal_load & (cal_target == acr_pkg::ACR_T_REF);
	wire cl_trim = cal_load & (cal_target == acr_pkg::ACR_T_TRIM);
	wire cl_prop = cal_load & (cal_target == acr_pkg::ACR_T_PROP);
	wire cl_gain = cal_load & (cal_target == acr_pkg::ACR_T_GAIN);
	// a calibrated gain is clamped into the calibration window
	wire [23:0] cal_gain = (cal_value < acr_pkg::GAIN_CAL_MIN) ? acr_pkg::GAIN_CAL_MIN :
		(cal_value > acr_pkg::GAIN_CAL_MAX) ? acr_pkg::GAIN_CAL_MAX : cal_value;
	// ************************************************************
	// next register values; a host write beats a calibration load
	// in the same cycle, since the host owns the final word
	// ************************************************************
	wire [23:0] nxt_in_ofs = wr_in ? merge(in_ofs_ff, avs_writedata, avs_byteenable) :
		cl_in ? cal_value : in_ofs_ff;
	wire [23:0] nxt_ref_ofs = wr_ref ? merge(ref_ofs_ff, avs_writedata, avs_byteenable) :
		cl_ref ? cal_value : ref_ofs_ff;
	wire [23:0] nxt_prop_ofs = wr_prop ? merge(prop_ofs_ff, avs_writedata, avs_byteenable) :
		cl_prop ? cal_value : prop_ofs_ff;
	// host gain is taken unclamped, any value up to 2 is legal
	wire [23:0] nxt_gain = wr_gain ? merge(gain_ff, avs_writedata, avs_byteenable) :
		cl_gain ? cal_gain : gain_ff;
	wire [3:0] nxt_trim = (wr_trim & avs_byteenable[0]) ? avs_writedata[3:0] :
		cl_trim ? cal_value[3:0] : trim_ff;
	wire nxt_en = (wr_ctrl & avs_byteenable[0]) ? avs_writedata[acr_pkg::CTRL_EN_BIT] : en_ff;
	// ************************************************************
	// status and read mux
	// ************************************************************
	wire st_cal = (gain_ff >= acr_pkg::GAIN_CAL_MIN) & (gain_ff <= acr_pkg::GAIN_CAL_MAX);
	wire st_lowres = gain_ff > acr_pkg::GAIN_CAL_MAX; // missing codes possible
	wire st_unsup = gain_ff < acr_pkg::GAIN_OP_MIN;
	wire [31:0] st_word = (32'(st_cal) << acr_pkg::ST_CAL_RANGE_BIT) |
		(32'(st_lowres) << acr_pkg::ST_LOW_RES_BIT) |
		(32'(st_unsup) << acr_pkg::ST_UNSUP_BIT);
	// unmapped offsets read as zero and ignore writes
	wire [31:0] rd_word =
		(avs_address == acr_pkg::ADDR_CTRL) ? {31'h0, en_ff} :
		(avs_address == acr_pkg::ADDR_IN_OFS) ? {8'h00, in_ofs_ff} :
		(avs_address == acr_pkg::ADDR_REF_OFS) ? {8'h00, ref_ofs_ff} :
		(avs_address == acr_pkg::ADDR_TRIM) ? {28'h0, trim_ff} :
		(avs_address == acr_pkg::ADDR_PROP_OFS) ? {8'h00, prop_ofs_ff} :
		(avs_address == acr_pkg::ADDR_GAIN) ? {8'h00, gain_ff} :
		(avs_address == acr_pkg::ADDR_STATUS) ? st_word :
		(avs_address == acr_pkg::ADDR_RESULT) ? {8'h00, last_ff} : 32'h0;
	// ************************************************************
	// correction arithmetic
	// ************************************************************
	// the proportional word only belongs to the input channel
	wire signed [25:0] raw_x = 26'(signed'(raw_data));
	wire signed [25:0] fix_x = 26'(signed'(raw_chan ? ref_ofs_ff : in_ofs_ff));
	wire signed [25:0] prop_x = raw_chan ? 26'sh0 : 26'(signed'(prop_ofs_ff));
	wire signed [25:0] nxt_diff = en_ff ? (raw_x - fix_x - prop_x) : raw_x;
	// 26 x 25 signed product, then drop the 23 fraction bits
	wire signed [50:0] prod = diff_ff * $signed({1'b0, gain_ff});
	wire fits = (&prod[50:46]) | ~(|prod[50:46]);
	wire [23:0] sat = fits ? prod[46:23] : (prod[50] ? acr_pkg::SAT_NEG : acr_pkg::SAT_POS);
	wire [23:0] nxt_res = byp1_ff ? diff_ff[23:0] : sat;
	// ************************************************************
	// bus handshake and read data
	// ************************************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wait_ff <= 1'b1;
			rdata_ff <= 32'h0;
		end else begin
			wait_ff <= ~acc;
			rdata_ff <= (acc & avs_read) ? rd_word : rdata_ff;
		end
	end
	// ************************************************************
	// calibration holders
	// ************************************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			en_ff <= acr_pkg::RST_CTRL_EN;
			in_ofs_ff <= acr_pkg::RST_OFS;
			ref_ofs_ff <= acr_pkg::RST_OFS;
			trim_ff <= acr_pkg::RST_TRIM;
			prop_ofs_ff <= acr_pkg::RST_OFS;
			gain_ff <= acr_pkg::RST_GAIN;
		end else begin
			en_ff <= nxt_en;
			in_ofs_ff <= nxt_in_ofs;
			ref_ofs_ff <= nxt_ref_ofs;
			trim_ff <= nxt_trim;
			prop_ofs_ff <= nxt_prop_ofs;
			gain_ff <= nxt_gain;
		end
	end
	// ************************************************************
	// two stage correction pipeline
	// ************************************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			v1_ff <= 1'b0;
			ch1_ff <= 1'b0;
			byp1_ff <= 1'b0;
			diff_ff <= 26'sh0;
		end else begin
			v1_ff <= raw_valid;
			ch1_ff <= raw_valid ? raw_chan : ch1_ff;
			byp1_ff <= raw_valid ? ~en_ff : byp1_ff;
			diff_ff <= raw_valid ? nxt_diff : diff_ff;
		end
	end
	// gain is sampled in stage two, so a new word hits the next sample
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			v2_ff <= 1'b0;
			ch2_ff <= 1'b0;
			res_ff <= 24'h000000;
			last_ff <= 24'h000000;
		end else begin
			v2_ff <= v1_ff;
			ch2_ff <= v1_ff ? ch1_ff : ch2_ff;
			res_ff <= v1_ff ? nxt_res : res_ff;
			last_ff <= v1_ff ? nxt_res : last_ff;
		end
	end
	// ************************************************************
	// outputs, all straight from flops
	// ************************************************************
	assign avs_waitrequest = wait_ff;
	assign avs_readdata = rdata_ff;
	assign trim_dac_code = trim_ff;
	assign out_valid = v2_ff;
	assign out_chan = ch2_ff;
	assign out_data = res_ff;
	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// one wait cycle, then an answer that stands for one cycle
	sequence s_take;
		(avs_read | avs_write) & avs_waitrequest;
	endsequence
	sequence s_ans;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence
	property p_bus_answer;
		s_take |=> s_ans;
	endproperty
	a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");
	// a full host write lands in the proportional word
	property p_host_prop;
		wr_prop & (avs_byteenable == 4'hF) |=> prop_ofs_ff == $past(avs_writedata[23:0]);
	endproperty
	a_host_prop: assert property (p_host_prop) else $error("prop write lost");
	// engine load of the input fixed offset
	property p_cal_in;
		cl_in & !wr_in |=> in_ofs_ff == $past(cal_value);
	endproperty
	a_cal_in: assert property (p_cal_in) else $error("offset load lost");
	// calibrated gain never leaves the window
	property p_gain_clamp;
		cl_gain & !wr_gain |=> (gain_ff >= 24'h666666) && (gain_ff <= 24'h999999);
	endproperty
	a_gain_clamp: assert property (p_gain_clamp) else $error("gain out of window");
	// host gain up to 2 is stored unclamped
	property p_host_gain;
		wr_gain & (avs_byteenable == 4'hF) |=> gain_ff == $past(avs_writedata[23:0]);
	endproperty
	a_host_gain: assert property (p_host_gain) else $error("host gain altered");
	// trim code follows its load
	property p_trim;
		cl_trim & !wr_trim |=> trim_dac_code == $past(cal_value[3:0]);
	endproperty
	a_trim: assert property (p_trim) else $error("trim not loaded");
	// reference channel ignores the proportional word
	property p_ref_path;
		raw_valid & raw_chan & en_ff |=>
			diff_ff == $past(raw_x) - $past(fix_x);
	endproperty
	a_ref_path: assert property (p_ref_path) else $error("ref path wrong");
	// every sample appears two cycles later
	sequence s_sample;
		raw_valid;
	endsequence
	property p_latency;
		s_sample |-> ##2 out_valid;
	endproperty
	a_latency: assert property (p_latency) else $error("output missing");
	// unity gain passes the difference unchanged
	property p_unity;
		v1_ff & !byp1_ff & (gain_ff == 24'h800000) & fits |=> out_data == $past(diff_ff[23:0]);
	endproperty
	a_unity: assert property (p_unity) else $error("unity gain wrong");
	// engine loads of the reference offset and the proportional word
	property p_cal_ref;
		cl_ref & !wr_ref |=> ref_ofs_ff == $past(cal_value);
	endproperty
	a_cal_ref: assert property (p_cal_ref) else $error("ref offset load lost");
	property p_cal_prop;
		cl_prop & !wr_prop |=> prop_ofs_ff == $past(cal_value);
	endproperty
	a_cal_prop: assert property (p_cal_prop) else $error("prop offset load lost");
	// host trim write reaches the dac pins in the next cycle
	property p_host_trim;
		wr_trim & avs_byteenable[0] |=> trim_dac_code == $past(avs_writedata[3:0]);
	endproperty
	a_host_trim: assert property (p_host_trim) else $error("host trim lost");
	// a taken read shows the addressed word during the answer cycle
	property p_read_data;
		avs_read & avs_waitrequest |=> avs_readdata == $past(rd_word);
	endproperty
	a_read_data: assert property (p_read_data) else $error("read data wrong");
	// with correction off the raw word passes stage one untouched
	property p_bypass;
		raw_valid & !en_ff |=> diff_ff == $past(raw_x);
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass altered data");
	// release of reset leaves unity gain
	property p_reset_gain;
		$past(rst) |-> gain_ff == 24'h800000;
	endproperty
	a_reset_gain: assert property (@(posedge clk) p_reset_gain) else $error("reset gain");
endmodule : acr_calib_regs

// [acr_host_model.sv]
// host microcontroller model: avalon master that reads and writes the calibration words
`timescale 1ns/1ns
module acr_host_model (
	input wire logic clk,
	output logic [7:0] avs_address,
	output logic avs_read,
	output logic avs_write,
	output logic [31:0] avs_writedata,
	output logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest
);
	// ************************************************************
	// idle bus at time zero
	// ************************************************************
	initial begin
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h00000000;
		avs_byteenable = 4'hF; // full words unless a lane test asks otherwise
	end
	// ************************************************************
	// one bus cycle, held until waitrequest is sampled low
	// ************************************************************
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] be, output logic [31:0] q);
		@(posedge clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= ~wr;
		avs_writedata <= d;
		avs_byteenable <= be;
		// wait as long as the slave needs; only the bench watchdog ends a hang
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata; // taken at the same edge as the answer
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		avs_writedata <= ~d; // released data no longer shows the last value
	endtask : xfer
endmodule : acr_host_model

// [acr_calib_regs_test.sv]
// self-checking bench of the calibration register set and correction path
`timescale 1ns/1ns
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module acr_calib_regs_test;
	// ************************************************************
	// signals
	// ************************************************************
	logic clk, rst, avs_read, avs_write, avs_waitrequest, raw_valid, raw_chan;
	logic cal_load, out_valid, out_chan;
	logic [7:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [3:0] avs_byteenable, trim_dac_code;
	logic [23:0] raw_data, cal_value, out_data;
	logic [2:0] cal_target;
	int errors = 0;
	int num_checks = 0;
	acr_calib_regs acr_calib_regs_i (.clk(clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .raw_valid(raw_valid), .raw_chan(raw_chan),
		.raw_data(raw_data), .cal_load(cal_load), .cal_target(cal_target),
		.cal_value(cal_value), .trim_dac_code(trim_dac_code), .out_valid(out_valid),
		.out_chan(out_chan), .out_data(out_data));
	acr_host_model acr_host_model_i (.clk(clk), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest));
	// ************************************************************
	// shared tasks
	// ************************************************************
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		acr_host_model_i.xfer(1'b1, a, d, 4'hF, q);
	endtask : wr
	// write with only some byte lanes enabled
	task automatic wr_be(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
		logic [31:0] q;
		acr_host_model_i.xfer(1'b1, a, d, be, q);
	endtask : wr_be
	task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		acr_host_model_i.xfer(1'b0, a, 32'h00000000, 4'hF, q);
		`CHK(nm, e, q)
	endtask : rd
	// one raw word in, corrected word expected exactly two edges later
	task automatic conv(input logic c, input logic [23:0] r, input logic [23:0] e);
		@(posedge clk);
		raw_valid <= 1'b1;
		raw_chan <= c;
		raw_data <= r;
		@(posedge clk);
		raw_valid <= 1'b0;
		raw_data <= ~r;
		#1 `CHK("early valid", 1'b0, out_valid)
		@(posedge clk);
		#1 `CHK("out valid", 1'b1, out_valid)
		`CHK("out chan", c, out_chan)
		`CHK("out data", e, out_data)
	endtask : conv
	task automatic cal(input logic [2:0] t, input logic [23:0] v);
		@(posedge clk);
		cal_load <= 1'b1;
		cal_target <= t;
		cal_value <= v;
		@(posedge clk);
		cal_load <= 1'b0;
	endtask : cal
	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic t_reset;
		rd("ctrl", acr_pkg::ADDR_CTRL, 32'h00000001);
		rd("in ofs", acr_pkg::ADDR_IN_OFS, 32'h00000000);
		rd("ref ofs", acr_pkg::ADDR_REF_OFS, 32'h00000000);
		rd("prop ofs", acr_pkg::ADDR_PROP_OFS, 32'h00000000);
		rd("gain", acr_pkg::ADDR_GAIN, 32'h00800000);
		`CHK("trim code", 4'h0, trim_dac_code)
		conv(1'b0, 24'h123456, 24'h123456);
		$display("test reset done");
	endtask : t_reset
	task automatic t_regs;
		logic [7:0] al[4];
		al = '{acr_pkg::ADDR_IN_OFS, acr_pkg::ADDR_REF_OFS, acr_pkg::ADDR_PROP_OFS,
			acr_pkg::ADDR_GAIN};
		// every word keeps 24 bits, the upper byte reads zero
		foreach (al[i]) begin
			wr(al[i], 32'hA5C35A1F ^ i);
			rd("word", al[i], 32'h00C35A1F ^ i);
		end
		wr(acr_pkg::ADDR_TRIM, 32'h000000FF);
		rd("trim", acr_pkg::ADDR_TRIM, 32'h0000000F);
		`CHK("trim code", 4'hF, trim_dac_code)
		wr_be(acr_pkg::ADDR_TRIM, 32'h00000003, 4'hE);
		rd("trim lane", acr_pkg::ADDR_TRIM, 32'h0000000F);
		wr_be(acr_pkg::ADDR_PROP_OFS, 32'hFF7788EE, 4'h2);
		rd("prop lane", acr_pkg::ADDR_PROP_OFS, 32'h00C3881D);
		wr(acr_pkg::ADDR_STATUS, 32'h00000007);
		rd("status ro", acr_pkg::ADDR_STATUS, 32'h00000002);
		wr(8'h20, 32'h12345678);
		rd("unmapped", 8'h20, 32'h00000000);
		$display("test registers done");
	endtask : t_regs
	task automatic t_path;
		wr(acr_pkg::ADDR_IN_OFS, 32'h00000100);
		wr(acr_pkg::ADDR_REF_OFS, 32'h00FFFF00);
		wr(acr_pkg::ADDR_PROP_OFS, 32'h00000010);
		wr(acr_pkg::ADDR_GAIN, 32'h00800000);
		conv(1'b0, 24'h001000, 24'h000EF0);
		conv(1'b1, 24'h001000, 24'h001100);
		conv(1'b0, 24'hFFF000, 24'hFFEEF0);
		wr(acr_pkg::ADDR_GAIN, 32'h00C00000);
		conv(1'b0, 24'h001000, 24'h001668);
		wr(acr_pkg::ADDR_REF_OFS, 32'h00000000);
		wr(acr_pkg::ADDR_GAIN, 32'h00FFFFFF);
		conv(1'b1, 24'h600000, 24'h7FFFFF);
		wr(acr_pkg::ADDR_CTRL, 32'h00000000);
		conv(1'b0, 24'h001000, 24'h001000);
		wr(acr_pkg::ADDR_CTRL, 32'h00000001);
		$display("test data path done");
	endtask : t_path
	task automatic t_status;
		logic [23:0] g[7];
		logic [31:0] s[7];
		g = '{24'h800000, 24'h666666, 24'h999999, 24'h99999A, 24'h666665, 24'h3FFFFF, 24'h400000};
		s = '{32'h1, 32'h1, 32'h1, 32'h2, 32'h0, 32'h4, 32'h0};
		// host words outside the calibration range are kept unclamped
		foreach (g[i]) begin
			wr(acr_pkg::ADDR_GAIN, {8'h00, g[i]});
			rd("gain", acr_pkg::ADDR_GAIN, {8'h00, g[i]});
			rd("status", acr_pkg::ADDR_STATUS, s[i]);
		end
		$display("test status done");
	endtask : t_status
	task automatic t_sets;
		logic [23:0] ofs[3], prop[3], gain[3], exp_w[3];
		// the host keeps one word set per gain stage and reloads it on a switch
		ofs = '{24'h000020, 24'h000040, 24'h000020};
		prop = '{24'h000010, 24'h000000, 24'h000010};
		gain = '{24'h800000, 24'hA00000, 24'h800000};
		exp_w = '{24'h000FD0, 24'h0013B0, 24'h000FD0};
		foreach (ofs[i]) begin
			wr(acr_pkg::ADDR_IN_OFS, {8'h00, ofs[i]});
			wr(acr_pkg::ADDR_PROP_OFS, {8'h00, prop[i]});
			wr(acr_pkg::ADDR_GAIN, {8'h00, gain[i]});
			conv(1'b0, 24'h001000, exp_w[i]);
		end
		rd("result", acr_pkg::ADDR_RESULT, 32'h00000FD0);
		$display("test word sets done");
	endtask : t_sets
	task automatic t_cal;
		// fixed offsets first, then trim and proportional, gain last
		cal(3'b000, 24'h0ABCDE);
		cal(3'b001, 24'hF12345);
		cal(3'b010, 24'h00000A);
		cal(3'b011, 24'h876543);
		cal(3'b100, 24'h100000);
		rd("in ofs", acr_pkg::ADDR_IN_OFS, 32'h000ABCDE);
		rd("ref ofs", acr_pkg::ADDR_REF_OFS, 32'h00F12345);
		rd("trim", acr_pkg::ADDR_TRIM, 32'h0000000A);
		`CHK("trim code", 4'hA, trim_dac_code)
		rd("prop ofs", acr_pkg::ADDR_PROP_OFS, 32'h00876543);
		rd("gain low", acr_pkg::ADDR_GAIN, 32'h00666666);
		cal(3'b100, 24'hF00000);
		rd("gain high", acr_pkg::ADDR_GAIN, 32'h00999999);
		cal(3'b101, 24'h000000);
		rd("gain kept", acr_pkg::ADDR_GAIN, 32'h00999999);
		$display("test calibration done");
	endtask : t_cal
	// ************************************************************
	// clock, verdict, watchdog and main sequence
	// ************************************************************
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic end_of_test;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		end_of_test();
	end
	initial begin
		rst = 1'b1;
		raw_valid = 1'b0;
		raw_chan = 1'b0;
		raw_data = 24'h000000;
		cal_load = 1'b0;
		cal_target = 3'b000;
		cal_value = 24'h000000;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_regs();
		t_path();
		t_status();
		t_sets();
		t_cal();
		// reset again in mid-run: every holder must return to its default
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		end_of_test();
	end
endmodule : acr_calib_regs_test
